// ### verilog/spi_audio_cfg.svh
`ifndef SPI_AUDIO_CFG_SVH
`define SPI_AUDIO_CFG_SVH

// Register byte offsets
`define OFS_CTRL 4'h0
`define OFS_TXDATA 4'h4
`define OFS_RXDATA 4'h8
`define OFS_STATUS 4'hC

// serial_port_control field positions
`define B_FSE 17
`define B_ENH 16
`define B_ON 15
`define B_STOP_IN_IDLE 13
`define B_DATA_OUT_PIN_DISABLE 12
`define B_W32 11
`define B_W16 10
`define B_SMP 9
`define B_CKE 8
`define B_SLAVE_SELECT_ENABLE 7
`define B_CKP 6
`define B_MST 5
`define B_AUD 4
`define B_FRM 3
`define CTRL_MASK 32'h0003BFF8
`define CTRL_RST 32'h00000000

// Status field positions
`define S_BUSY 0
`define S_TXFULL 1
`define S_RXVALID 2
`define S_CHAN 3

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### verilog/spi_audio_pkg.sv
package spi_audio_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_SHIFT} link_state_t;
  typedef logic [1:0] width_code_t;

  // Significant data bits of one word
  function automatic logic [5:0] data_bits(input width_code_t w, input logic aud);
    if (aud)
      data_bits = w[1] ? (w[0] ? 6'd24 : 6'd32) : 6'd16;
    else
      data_bits = w[1] ? 6'd32 : (w[0] ? 6'd16 : 6'd8);
  endfunction

  // Bit clocks per word (one audio channel)
  function automatic logic [5:0] chan_bits(input width_code_t w, input logic aud);
    if (aud)
      chan_bits = (w == 2'b00) ? 6'd16 : 6'd32;
    else
      chan_bits = data_bits(w, aud);
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] st);
    for (int i = 0; i < 4; i++)
      strb_merge[i*8 +: 8] = st[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
  endfunction
endpackage

// ### verilog/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  initial assert (WIDTH > 0) else $error("level_sync WIDTH must be positive");

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // level_sync

// ### verilog/toggle_sync.sv
`timescale 1ns/1ps
module toggle_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic tgl,
  output logic pulse
);
  logic meta;
  logic s1;
  logic s2;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      s1 <= 1'b0;
      s2 <= 1'b0;
    end
    else
    begin
      meta <= tgl;
      s1 <= meta;
      s2 <= s1;
    end
  end

  assign pulse = s1 ^ s2;
endmodule // toggle_sync

// ### verilog/spi_audio_serial_control.sv
// Behaviour
// - Framed sync with or before first clock
// - Enhanced bit enables second transmit word
// - On bit gates port; buffer bit locked
// - Stop-in-idle halts port during processor idle
// - Output-disable releases serial data pin
// - Audio 11/10: 24/32 data, 32 channel
// - Audio 01: 16 in 32; 00: 16 in 16
// - Plain mode words 32, 16, 8 bits
// - Master samples middle or end by phase bit
// - Slave always samples mid bit
// - Clock-edge bit picks output change edge
// - Clock-edge bit ignored in framed mode
// - Slave select pin qualifies slave transfers
// - Polarity bit sets idle clock level
// - Audio mode forces idle-high clock
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "spi_audio_cfg.svh"
module spi_audio_serial_control (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Processor idle indication
  input wire logic cpu_idle,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link clock
  input wire logic link_clk,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  output logic serial_data_out_pin,
  output logic serial_data_out_oe,
  input wire logic serial_data_in,
  input wire logic slave_select_pin_n,
  output logic frame_sync_out,
  output logic frame_sync_oe
);
  import spi_audio_pkg::*;

  // System domain
  logic [31:0] serial_port_control;
  logic aw_got;
  logic w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] tx_hold;
  logic hold_busy;
  logic [31:0] tx_next;
  logic next_valid;
  logic req_tgl;
  logic [31:0] rx_data;
  logic rx_valid;
  logic rx_chan_sys;
  logic ack_pulse;
  logic done_pulse;
  logic busy_sys;
  logic tx_wr;
  logic rx_rd;
  logic on;
  logic enh;
  logic tx_full;

  assign on = serial_port_control[`B_ON];
  assign enh = serial_port_control[`B_ENH];
  assign tx_full = enh ? next_valid : hold_busy;

  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign tx_wr = wr_fire & (aw_addr == `OFS_TXDATA);
  assign rx_rd = rd_fire & (s_axi_araddr == `OFS_RXDATA);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == `OFS_CTRL || aw_addr == `OFS_TXDATA) ?
            `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      serial_port_control <= `CTRL_RST;
    else if (wr_fire && aw_addr == `OFS_CTRL)
    begin
      serial_port_control <= strb_merge(serial_port_control, w_data, w_strb) & `CTRL_MASK;
      if (on)
        serial_port_control[`B_ENH] <= enh;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      unique case (s_axi_araddr)
        `OFS_CTRL: s_axi_rdata <= serial_port_control;
        `OFS_TXDATA: s_axi_rdata <= tx_hold;
        `OFS_RXDATA: s_axi_rdata <= rx_data;
        `OFS_STATUS: s_axi_rdata <= {28'h0000000, rx_chan_sys, rx_valid, tx_full, busy_sys};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_hold <= '0;
      hold_busy <= 1'b0;
      tx_next <= '0;
      next_valid <= 1'b0;
      req_tgl <= 1'b0;
    end
    else if (!on)
    begin
      hold_busy <= 1'b0;
      next_valid <= 1'b0;
    end
    else if (ack_pulse && hold_busy)
    begin
      // Link has taken tx_hold; refill from the queue or the new write
      if (next_valid)
      begin
        tx_hold <= tx_next;
        req_tgl <= ~req_tgl;
        next_valid <= tx_wr;
        if (tx_wr)
          tx_next <= w_data;
      end
      else if (tx_wr)
      begin
        tx_hold <= w_data;
        req_tgl <= ~req_tgl;
      end
      else
        hold_busy <= 1'b0;
    end
    else if (tx_wr && !hold_busy)
    begin
      tx_hold <= w_data;
      hold_busy <= 1'b1;
      req_tgl <= ~req_tgl;
    end
    else if (tx_wr && enh && !next_valid)
    begin
      tx_next <= w_data;
      next_valid <= 1'b1;
    end
  end

  // Received word; a new word wins over a same-cycle read clear
  logic [31:0] rx_word;
  logic rx_chan;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_data <= '0;
      rx_valid <= 1'b0;
      rx_chan_sys <= 1'b0;
    end
    else if (done_pulse)
    begin
      rx_data <= rx_word;
      rx_chan_sys <= rx_chan;
      rx_valid <= 1'b1;
    end
    else if (rx_rd)
      rx_valid <= 1'b0;
  end

  // Crossings
  logic [11:0] cfg_src;
  logic [11:0] cfg;
  logic [2:0] pins;
  logic sck_s;
  logic sdi_s;
  logic ss_n_s;
  logic ack_tgl;
  logic done_tgl;
  logic busy_link;
  logic req_pulse;

  assign cfg_src = {on, serial_port_control[`B_STOP_IN_IDLE] & cpu_idle,
      serial_port_control[`B_MST], serial_port_control[`B_AUD],
      serial_port_control[`B_FRM], serial_port_control[`B_W32],
      serial_port_control[`B_W16], serial_port_control[`B_SMP],
      serial_port_control[`B_CKE], serial_port_control[`B_SLAVE_SELECT_ENABLE],
      serial_port_control[`B_CKP], serial_port_control[`B_FSE]};

  level_sync #(.WIDTH(12)) u_cfg_sync (
    .clk(link_clk),
    .rst(sys_rst),
    .d(cfg_src),
    .q(cfg)
  );

  level_sync #(.WIDTH(3)) u_pin_sync (
    .clk(link_clk),
    .rst(sys_rst),
    .d({sck_in, serial_data_in, slave_select_pin_n}),
    .q(pins)
  );

  level_sync #(.WIDTH(1)) u_busy_sync (
    .clk(clk_sys),
    .rst(sys_rst),
    .d(busy_link),
    .q(busy_sys)
  );

  toggle_sync u_req_sync (
    .clk(link_clk),
    .rst(sys_rst),
    .tgl(req_tgl),
    .pulse(req_pulse)
  );

  toggle_sync u_ack_sync (
    .clk(clk_sys),
    .rst(sys_rst),
    .tgl(ack_tgl),
    .pulse(ack_pulse)
  );

  toggle_sync u_done_sync (
    .clk(clk_sys),
    .rst(sys_rst),
    .tgl(done_tgl),
    .pulse(done_pulse)
  );

  // Link domain
  logic c_on, c_halt, c_mst, c_aud, c_frm, c_smp, c_cke, c_slave_select_enable, c_ckp, c_fse;
  width_code_t c_w;
  assign {c_on, c_halt, c_mst, c_aud, c_frm, c_w, c_smp, c_cke, c_slave_select_enable, c_ckp, c_fse} = cfg;
  assign {sck_s, sdi_s, ss_n_s} = pins;

  link_state_t st;
  logic have_req;
  logic phase;
  logic first;
  logic act_d;
  logic chan;
  logic [5:0] cnt;
  logic [31:0] sh;
  logic [31:0] rx_sh;
  logic [31:0] next_rx;
  logic [5:0] nbits;
  logic [5:0] dbits;
  logic ckp_e;
  logic cke_e;
  logic act;
  logic rise;
  logic fall;
  logic running;
  logic ch_evt;
  logic sm_evt;
  logic start;
  logic [5:0] rcnt;
  logic [1:0] smp_pipe;
  logic rx_evt;

  assign nbits = chan_bits(c_w, c_aud);
  assign dbits = data_bits(c_w, c_aud);
  assign ckp_e = c_aud | c_ckp;
  assign cke_e = c_cke & ~c_frm;
  assign act = c_mst ? phase : (sck_s ^ ckp_e);
  // slave select
  // Clock stops after the last sample moment while captures drain
  assign running = (st == ST_SHIFT) & (cnt != nbits) & ~c_halt
      & (c_mst | ~c_slave_select_enable | ~ss_n_s);
  assign rise = c_mst ? ~phase : (act & ~act_d);
  assign fall = c_mst ? phase : (~act & act_d);
  assign ch_evt = running & (cke_e ? fall : rise);
  assign sm_evt = running & ((c_mst & c_smp) ? ch_evt : (cke_e ? rise : fall));
  assign next_rx = {rx_sh[30:0], sdi_s};
  // Master data returns two link edges late through the input synchroniser
  assign rx_evt = c_mst ? smp_pipe[1] : sm_evt;
  assign start = (have_req | req_pulse) & c_on & ~c_halt;
  assign busy_link = (st != ST_IDLE) | have_req;

  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
      act_d <= 1'b0;
    else
      act_d <= act;
  end

  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
      smp_pipe <= '0;
    else if (!c_on)
      smp_pipe <= '0;
    else
      smp_pipe <= {smp_pipe[0], sm_evt & c_mst};
  end

  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= ST_IDLE;
      have_req <= 1'b0;
      phase <= 1'b0;
      first <= 1'b0;
      chan <= 1'b0;
      cnt <= '0;
      sh <= '0;
      rx_sh <= '0;
      rcnt <= '0;
      rx_word <= '0;
      rx_chan <= 1'b0;
      ack_tgl <= 1'b0;
      done_tgl <= 1'b0;
    end
    else if (!c_on)
    begin
      st <= ST_IDLE;
      have_req <= 1'b0;
      phase <= 1'b0;
      chan <= 1'b0;
    end
    else
    begin
      if (req_pulse)
        have_req <= 1'b1;
      unique case (st)
        ST_IDLE:
        begin
          if (start)
          begin
            sh <= tx_hold << (6'd32 - dbits);
            have_req <= 1'b0;
            ack_tgl <= ~ack_tgl;
            cnt <= '0;
            rcnt <= '0;
            rx_sh <= '0;
            phase <= 1'b0;
            first <= 1'b1;
            st <= (c_mst & c_frm & ~c_aud & ~c_fse) ? ST_PRE : ST_SHIFT;
          end
        end
        ST_PRE:
        begin
          if (!c_halt)
          begin
            phase <= ~phase;
            if (phase)
              st <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (running && c_mst)
            phase <= ~phase;
          if (ch_evt)
          begin
            first <= 1'b0;
            if (!first || cke_e)
              sh <= sh << 1;
          end
          if (sm_evt)
            cnt <= cnt + 6'd1;
          if (rx_evt)
          begin
            rx_sh <= next_rx;
            rcnt <= rcnt + 6'd1;
            if (rcnt == nbits - 6'd1)
            begin
              rx_word <= next_rx >> (nbits - dbits);
              rx_chan <= chan;
              done_tgl <= ~done_tgl;
              chan <= c_aud ? ~chan : 1'b0;
              phase <= 1'b0;
              st <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Pins
  // role and mode bits
  assign sck_oe = c_on & c_mst;
  assign sck_out = ckp_e ^ ((st == ST_SHIFT) & phase);
  assign serial_data_out_oe = c_on & ~serial_port_control[`B_DATA_OUT_PIN_DISABLE];
  assign serial_data_out_pin = sh[31];
  assign frame_sync_oe = c_on & c_mst & (c_frm | c_aud);
  assign frame_sync_out = c_aud ? chan :
      ((st == ST_PRE) | ((st == ST_SHIFT) & c_fse & (cnt == 6'd0)));
endmodule // spi_audio_serial_control

// ### verif/spi_audio_serial_control_assertions.sv
`timescale 1ns/1ps
module spi_audio_serial_control_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Link pins
  input wire logic sck_oe,
  input wire logic frame_sync_oe
);
  // Link outputs come straight from link registers, so sampling here is safe
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_wblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_arblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_rst;
    disable iff (1'b0) sys_rst |-> !s_axi_bvalid && !s_axi_rvalid && !sck_oe;
  endproperty
  property p_fsoe;
    frame_sync_oe |-> sck_oe;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  a_rd: assert property (p_rd) else $error("read answer late");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  a_wblk: assert property (p_wblk) else $error("write taken while answering");
  a_arblk: assert property (p_arblk) else $error("read taken while answering");
  a_rst: assert property (p_rst) else $error("active during reset");
  a_fsoe: assert property (p_fsoe) else $error("sync driven outside master");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_fs: cover property (frame_sync_oe);
endmodule // spi_audio_serial_control_checker
bind spi_audio_serial_control spi_audio_serial_control_checker u_chk (.clk_sys, .sys_rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sck_oe,
  .frame_sync_oe);

// ### verif/serial_peer_model.sv
`timescale 1ns/1ps
module serial_peer_model (
  // Serial lines
  input wire logic sck,
  input wire logic sck_oe,
  input wire logic sdo,
  output logic sdi,
  // Settings and words
  input wire logic clock_polarity_select,
  input wire logic cke,
  input wire logic clr,
  input wire logic [5:0] nbits,
  input wire logic [31:0] tx_word,
  output logic [31:0] rx_word
);
  logic [31:0] sh;
  int cnt;
  int idx;
  initial
  begin
    sdi = 1'b0;
    rx_word = '0;
  end
  always @(posedge clr)
  begin
    cnt = 0;
    idx = 0;
    sh = '0;
  end
  always @(sck)
    if (sck_oe && ((sck != clock_polarity_select) == cke))
    begin
      sh = {sh[30:0], sdo};
      cnt++;
      if (cnt == nbits)
      begin
        rx_word = sh;
        cnt = 0;
        idx = 0;
        sh = '0;
      end
    end
    else if (sck_oe && cnt != 0)
      idx++;
  // Released line shows the inverse of its last bit
  always @(idx or tx_word or nbits or sck_oe)
    sdi = sck_oe ? tx_word[nbits - 1 - idx] : ~sdi;
endmodule // serial_peer_model

// ### verif/test_spi_audio_serial_control.sv
`timescale 1ns/1ps
`include "spi_audio_cfg.svh"
module test_spi_audio_serial_control;
  logic clk_sys, sys_rst, cpu_idle, link_clk, sck_in, slave_select_pin_n;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, q, tx, cfg, ctrl, w, p_tx, p_rx;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic sck_out, sck_oe, serial_data_out_pin, serial_data_out_oe, serial_data_in;
  logic frame_sync_out, frame_sync_oe, p_ckp, p_cke, p_clr;
  logic [5:0] p_n;
  int bad_count, n_checks, k;
  spi_audio_serial_control uut (.clk_sys, .sys_rst, .cpu_idle, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .sck_in, .sck_out, .sck_oe,
    .serial_data_out_pin, .serial_data_out_oe, .serial_data_in, .slave_select_pin_n,
    .frame_sync_out, .frame_sync_oe);
  serial_peer_model peer (.sck(sck_out), .sck_oe, .sdo(serial_data_out_pin),
    .sdi(serial_data_in), .clock_polarity_select(p_ckp), .cke(p_cke), .clr(p_clr), .nbits(p_n),
    .tx_word(p_tx), .rx_word(p_rx));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Odd start keeps the link clock out of phase
  initial
  begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Handshakes judged from values settled before the edge
  task axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
    logic ha, hw, hd;
    int i;
    hd = 1'b0;
    @(posedge clk_sys);
    if (wr)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (i = 0; i < 40 && !hd; i++)
    begin
      @(negedge clk_sys);
      ha = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      hw = s_axi_wvalid && s_axi_wready;
      hd = wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge clk_sys);
      if (ha)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (hw)
        s_axi_wvalid <= 1'b0;
      if (hd)
      begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
    if (!hd)
    begin
      bad_count++;
      stop_test();
    end
  endtask
  function automatic logic [5:0] nb(input logic [31:0] c);
    nb = c[`B_W32] ? 6'd32 : (c[`B_W16] ? 6'd16 : 6'd8);
  endfunction
  function automatic logic [31:0] msk(input logic [31:0] c);
    msk = (nb(c) == 6'd32) ? 32'hFFFFFFFF : (32'h1 << nb(c)) - 32'h1;
  endfunction
  function automatic logic [31:0] exp_ctrl(input logic [31:0] old, input logic [31:0] v);
    exp_ctrl = v & `CTRL_MASK;
    if (old[`B_ON])
      exp_ctrl[`B_ENH] = old[`B_ENH];
  endfunction
  task xfer(input logic idl);
    int i;
    p_ckp <= cfg[`B_CKP];
    p_cke <= cfg[`B_CKE];
    p_n <= nb(cfg);
    p_tx <= $urandom;
    tx = $urandom;
    axi(1'b1, `OFS_CTRL, cfg);
    repeat (200) @(posedge clk_sys);
    p_clr <= 1'b1;
    cpu_idle <= idl;
    @(posedge clk_sys);
    p_clr <= 1'b0;
    axi(1'b1, `OFS_TXDATA, tx);
    q = '0;
    if (idl)
    begin
      // Longer than a whole 32-bit word, so a missing halt shows
      repeat (4000) @(posedge clk_sys);
      axi(1'b0, `OFS_STATUS, '0);
      chk(32'(q[`S_RXVALID]), 32'h0);
      cpu_idle <= 1'b0;
    end
    for (i = 0; i < 2000 && q[`S_RXVALID] !== 1'b1; i++)
      axi(1'b0, `OFS_STATUS, '0);
    chk(32'(q[`S_RXVALID]), 32'h1);
    if (q[`S_RXVALID] !== 1'b1)
      stop_test();
    axi(1'b0, `OFS_RXDATA, '0);
    chk(q & msk(cfg), p_tx & msk(cfg));
    chk(32'(serial_data_out_oe), 32'(!cfg[`B_DATA_OUT_PIN_DISABLE]));
    if (!cfg[`B_DATA_OUT_PIN_DISABLE])
      chk(p_rx & msk(cfg), tx & msk(cfg));
  endtask
  initial
  begin
    sys_rst = 1'b1;
    {cpu_idle, sck_in, p_clr, p_ckp, p_cke, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    slave_select_pin_n = 1'b1;
    p_n = 6'd8;
    p_tx = '0;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(32'h452d7a4e));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    axi(1'b0, `OFS_CTRL, '0);
    chk(q, `CTRL_RST);
    ctrl = `CTRL_RST;
    for (k = 0; k < 12; k++)
    begin
      w = (k == 4) ? 32'h0 : (k == 5) ? 32'h8000 : (k == 6) ? 32'h18000 : $urandom;
      axi(1'b1, `OFS_CTRL, w);
      chk(32'(r), 32'(`RESP_OKAY));
      axi(1'b0, `OFS_CTRL, '0);
      ctrl = exp_ctrl(ctrl, w);
      chk(q, ctrl);
    end
    axi(1'b1, `OFS_STATUS, 32'hFFFFFFFF);
    chk(32'(r), 32'(`RESP_SLVERR));
    for (k = 0; k < 4; k++)
    begin
      cfg = 32'h00008020;
      cfg[`B_CKP] = k[0];
      cfg[`B_AUD] = k[1];
      axi(1'b1, `OFS_CTRL, cfg);
      repeat (200) @(posedge clk_sys);
      chk(32'(sck_out), 32'(k[0] | k[1]));
      chk(32'(sck_oe), 32'h1);
    end
    for (k = 0; k < 8; k++)
    begin
      cfg = 32'h00008020;
      cfg[11:10] = k[1:0];
      cfg[`B_CKE] = k[2];
      cfg[`B_CKP] = 1'($urandom);
      cfg[`B_DATA_OUT_PIN_DISABLE] = (k == 7);
      cfg[`B_STOP_IN_IDLE] = (k == 3);
      xfer(k == 3);
    end
    stop_test();
  end
endmodule // test_spi_audio_serial_control
